// *** hw/ipd_detector.sv ***
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ipd_detector
  import ipd_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                nrst_i,
  input  wire logic [7:0]          addr_i,
  input  wire logic [7:0]          wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [7:0]          rdata_o,
  input  wire logic [1:0][15:0]    iir_out_i,
  input  wire logic [15:0]         power_i,
  output logic      [1:0][1:0]     path_flag_o,
  output logic      [1:0]          rms_flag_o,
  output logic                     rms_avg_valid_o,
  output logic      [15:0]         rms_avg_o,
  output logic                     irq_o
);
  ipd_state_s st;
  ipd_state_s next_st;
  logic [IRQ_W-1:0] ev;
  logic [1:0]       above;
  logic [1:0]       below;
  logic [16:0]      blk_len;
  logic [47:0]      sum;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cmp
      // Thresholds and filter output share the signed 2.14 scale.
      assign above[g] = $signed(iir_out_i[g]) > st.path[g].upper; // RULE1
      assign below[g] = $signed(iir_out_i[g]) < st.path[g].lower;
    end
  endgenerate

  // Settings above sixteen are clamped so the block never grows beyond two to sixteen.
  assign blk_len = 17'h00001 << ((st.rms_exp > RMS_EXP_MAX) ? RMS_EXP_MAX : st.rms_exp); // RULE6
  assign sum     = st.acc + {32'h00000000, power_i};

  always_comb begin
    next_st = st;
    ev      = '0;
    next_st.rdata     = 8'h00;
    next_st.avg_valid = 1'b0;
    for (int p = 0; p < 2; p++) begin
      if (above[p]) begin
        if (!st.peak[p]) ev[2*p] = 1'b1;
        next_st.peak[p]  = 1'b1; // RULE3
        next_st.dwell[p] = 16'h0000;
      end else if (st.peak[p] && below[p]) begin
        // The dwell run restarts whenever the output leaves the region below the lower limit.
        if (st.dwell[p] >= st.hold) begin
          next_st.peak[p]  = 1'b0; // RULE4
          next_st.dwell[p] = 16'h0000;
          ev[2*p+1]        = 1'b1;
        end else begin
          next_st.dwell[p] = st.dwell[p] + 16'h0001;
        end
      end else begin
        next_st.dwell[p] = 16'h0000;
      end
    end
    if (st.rms_on) begin // RULE5
      if (st.blk_cnt + 17'h00001 >= blk_len) begin
        next_st.blk_cnt   = '0;
        next_st.acc       = '0;
        next_st.avg       = 16'(sum >> ((st.rms_exp > RMS_EXP_MAX) ? RMS_EXP_MAX : st.rms_exp)); // RULE6
        next_st.avg_valid = 1'b1;
      end else begin
        next_st.blk_cnt = st.blk_cnt + 17'h00001;
        next_st.acc     = sum;
      end
    end else begin
      next_st.blk_cnt  = '0;
      next_st.acc      = '0;
      next_st.rms_flag = 2'b00;
    end
    if (st.avg_valid) begin
      next_st.rms_flag[0] = st.avg > st.rms_upper; // RULE7
      next_st.rms_flag[1] = st.avg < st.rms_lower; // RULE7
      ev[4] = st.avg > st.rms_upper;
      ev[5] = st.avg < st.rms_lower;
    end
    if (wr_i) begin
      unique case (addr_i)
        OFS_P0_UP_LO:  next_st.path[0].upper[7:0]  = wdata_i; // RULE8
        OFS_P0_UP_HI:  next_st.path[0].upper[15:8] = wdata_i; // RULE8
        OFS_P0_LO_LO:  next_st.path[0].lower[7:0]  = wdata_i;
        OFS_P0_LO_HI:  next_st.path[0].lower[15:8] = wdata_i;
        OFS_P0_FMT:    next_st.path[0].wide        = wdata_i[0]; // RULE2
        OFS_P1_UP_LO:  next_st.path[1].upper[7:0]  = wdata_i;
        OFS_P1_UP_HI:  next_st.path[1].upper[15:8] = wdata_i;
        OFS_P1_LO_LO:  next_st.path[1].lower[7:0]  = wdata_i;
        OFS_P1_LO_HI:  next_st.path[1].lower[15:8] = wdata_i;
        OFS_P1_FMT:    next_st.path[1].wide        = wdata_i[0]; // RULE2
        OFS_HOLD_LO:   next_st.hold[7:0]           = wdata_i;
        OFS_HOLD_HI:   next_st.hold[15:8]          = wdata_i;
        OFS_RMS_EN:    next_st.rms_on              = wdata_i[0];
        OFS_RMS_EXP:   next_st.rms_exp             = wdata_i[4:0];
        OFS_RMS_UP_LO: next_st.rms_upper[7:0]      = wdata_i;
        OFS_RMS_UP_HI: next_st.rms_upper[15:8]     = wdata_i;
        OFS_RMS_LO_LO: next_st.rms_lower[7:0]      = wdata_i;
        OFS_RMS_LO_HI: next_st.rms_lower[15:8]     = wdata_i;
        OFS_IRQ_MASK:  next_st.irq_mask            = wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
    // A new event in the same cycle as a write-one-to-clear keeps its bit set.
    if (wr_i && addr_i == OFS_IRQ_STAT) begin
      next_st.irq_stat = (st.irq_stat & ~wdata_i[IRQ_W-1:0]) | ev;
    end else begin
      next_st.irq_stat = st.irq_stat | ev;
    end
    if (rd_i) begin
      unique case (addr_i)
        OFS_P0_UP_LO:  next_st.rdata = st.path[0].upper[7:0];
        OFS_P0_UP_HI:  next_st.rdata = st.path[0].upper[15:8];
        OFS_P0_LO_LO:  next_st.rdata = st.path[0].lower[7:0];
        OFS_P0_LO_HI:  next_st.rdata = st.path[0].lower[15:8];
        OFS_P0_FMT:    next_st.rdata = {7'h00, st.path[0].wide};
        OFS_P1_UP_LO:  next_st.rdata = st.path[1].upper[7:0];
        OFS_P1_UP_HI:  next_st.rdata = st.path[1].upper[15:8];
        OFS_P1_LO_LO:  next_st.rdata = st.path[1].lower[7:0];
        OFS_P1_LO_HI:  next_st.rdata = st.path[1].lower[15:8];
        OFS_P1_FMT:    next_st.rdata = {7'h00, st.path[1].wide};
        OFS_HOLD_LO:   next_st.rdata = st.hold[7:0];
        OFS_HOLD_HI:   next_st.rdata = st.hold[15:8];
        OFS_RMS_EN:    next_st.rdata = {7'h00, st.rms_on};
        OFS_RMS_EXP:   next_st.rdata = {3'h0, st.rms_exp};
        OFS_RMS_UP_LO: next_st.rdata = st.rms_upper[7:0];
        OFS_RMS_UP_HI: next_st.rdata = st.rms_upper[15:8];
        OFS_RMS_LO_LO: next_st.rdata = st.rms_lower[7:0];
        OFS_RMS_LO_HI: next_st.rdata = st.rms_lower[15:8];
        OFS_IRQ_STAT:  next_st.rdata = {2'h0, st.irq_stat};
        OFS_IRQ_MASK:  next_st.rdata = {2'h0, st.irq_mask};
        OFS_FLAGS:     next_st.rdata = {4'h0, st.rms_flag, st.peak};
        default:       next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      st           <= '0;
      st.hold      <= RST_WORD;
      st.rms_upper <= RST_WORD;
      st.rms_lower <= RST_WORD;
    end else begin
      st <= next_st;
    end
  end

  generate
    for (g = 0; g < 2; g++) begin : g_out
      // Bit 1 repeats the flag only in two-bit format; single-bit format holds it low.
      assign path_flag_o[g] = {st.path[g].wide & st.peak[g], st.peak[g]}; // RULE2
    end
  endgenerate
  assign rms_flag_o      = st.rms_flag;
  assign rms_avg_o       = st.avg;
  assign rms_avg_valid_o = st.avg_valid;
  assign rdata_o         = st.rdata;
  assign irq_o           = |(st.irq_stat & st.irq_mask);

  a_peak_set: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE3
    above[0] |=> st.peak[0]) else $error("Path0 flag not set above upper limit.");
  a_peak_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE4
    (st.peak[0] && !below[0]) |=> st.peak[0]) else $error("Path0 flag cleared without dwell.");
  a_dwell_cnt: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE4
    $fell(st.peak[0]) |-> $past(st.dwell[0]) >= $past(st.hold)) else $error("Path0 cleared early.");
  a_narrow_fmt: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE2
    !st.path[1].wide |-> !path_flag_o[1][1]) else $error("Wide bit set in narrow format.");
  a_rms_off: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE5
    !st.rms_on |=> !rms_avg_valid_o) else $error("RMS result while disabled.");
  a_rms_high: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE7
    rms_avg_valid_o |=> rms_flag_o[0] == ($past(rms_avg_o) > $past(st.rms_upper))) else $error("RMS high wrong.");
  a_rms_low: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE7
    rms_avg_valid_o |=> rms_flag_o[1] == ($past(rms_avg_o) < $past(st.rms_lower))) else $error("RMS low wrong.");
  a_blk_len: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE6
    (st.rms_on && st.rms_exp == 5'h00 && $past(st.rms_on)) |-> ##1 rms_avg_valid_o)
    else $error("Unit block missed.");
  a_byte_pair: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE8
    (wr_i && addr_i == OFS_HOLD_HI) |=> st.hold[15:8] == $past(wdata_i)) else $error("Hold high byte lost.");
  a_thr_sign: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE1
    (st.path[1].upper[15] && !iir_out_i[1][15]) |-> above[1]) else $error("Signed compare wrong.");
  c_peak_cycle: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) $fell(st.peak[0]));
  c_rms_block:  cover property (@(posedge sys_clk_i) disable iff (!nrst_i) rms_avg_valid_o && st.rms_exp == 5'h04);
  c_irq:        cover property (@(posedge sys_clk_i) disable iff (!nrst_i) $rose(irq_o));
  c_path1_pk:   cover property (@(posedge sys_clk_i) disable iff (!nrst_i) $rose(st.peak[1]));
  c_unit_blk:   cover property (@(posedge sys_clk_i) disable iff (!nrst_i) rms_avg_valid_o && st.rms_exp == 5'h00);

  // Both paths obey the same flag rules, so their checks are generated once per path.
  generate
    for (g = 0; g < 2; g++) begin : g_chk
      a_path_set: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE3
        above[g]
        |=> st.peak[g])
        else $error("Flag not set above upper limit.");

      a_path_rise: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE3
        $rose(st.peak[g])
        |-> $past(above[g]))
        else $error("Flag rose without a crossing.");

      a_path_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE4
        (st.peak[g] && !below[g])
        |=> st.peak[g])
        else $error("Flag cleared while not below lower limit.");

      a_path_dwell: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE4
        $fell(st.peak[g])
        |-> $past(st.dwell[g]) >= $past(st.hold))
        else $error("Flag cleared before the dwell ran out.");

      a_dwell_idle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE4
        !st.peak[g]
        |-> st.dwell[g] == 16'h0000)
        else $error("Dwell count running without a flag.");

      a_wide_fmt: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE2
        (st.path[g].wide && st.peak[g])
        |-> path_flag_o[g] == 2'b11)
        else $error("Two-bit flag not shown.");

      a_set_event: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE3
        $rose(st.peak[g])
        |-> st.irq_stat[2*g])
        else $error("Set event not recorded.");

      a_clr_event: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE4
        $fell(st.peak[g])
        |-> st.irq_stat[2*g+1])
        else $error("Clear event not recorded.");
    end
  endgenerate

  // Blocks of two or more samples can never end in two cycles in a row.
  a_valid_pulse: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE6
    (rms_avg_valid_o && st.rms_exp != 5'h00)
    |=> !rms_avg_valid_o)
    else $error("Block result repeated too soon.");

  a_unit_avg: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE6
    (st.rms_on && st.rms_exp == 5'h00 && st.blk_cnt == 17'h00000 && st.acc == 48'h000000000000)
    |=> rms_avg_o == $past(power_i))
    else $error("Unit block average wrong.");

  a_exp_clamp: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE6
    (st.rms_exp > RMS_EXP_MAX)
    |-> blk_len == 17'h10000)
    else $error("Block length not clamped.");

  a_rms_clear: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE5
    !st.rms_on
    |=> (st.blk_cnt == 17'h00000 && st.acc == 48'h000000000000))
    else $error("Accumulator running while disabled.");

  a_rms_flag_off: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE5
    (!st.rms_on && !rms_avg_valid_o)
    |=> rms_flag_o == 2'b00)
    else $error("RMS flags kept while disabled.");

  a_rms_ev_hi: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE7
    (st.avg_valid && st.avg > st.rms_upper)
    |=> st.irq_stat[4])
    else $error("High power event lost.");

  a_rms_ev_lo: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE7
    (st.avg_valid && st.avg < st.rms_lower)
    |=> st.irq_stat[5])
    else $error("Low power event lost.");

  // Status bits are sticky: only a write to the status register may drop one.
  a_irq_sticky: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE3
    !(wr_i && addr_i == OFS_IRQ_STAT)
    |=> (st.irq_stat & $past(st.irq_stat)) == $past(st.irq_stat))
    else $error("Status bit dropped without a write.");

  a_w1c_clear: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE4
    (wr_i && addr_i == OFS_IRQ_STAT && ev == 6'h00)
    |=> (st.irq_stat & $past(wdata_i[IRQ_W-1:0])) == 6'h00)
    else $error("Status bit not cleared by write.");

  a_rd_idle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE8
    !rd_i
    |=> rdata_o == 8'h00)
    else $error("Read data shown without a read.");

  a_rd_back: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE8
    (rd_i && addr_i == OFS_HOLD_HI)
    |=> rdata_o == $past(st.hold[15:8]))
    else $error("Hold high byte read wrong.");

  a_hold_lo: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE8
    (wr_i && addr_i == OFS_HOLD_LO)
    |=> st.hold[7:0] == $past(wdata_i))
    else $error("Hold low byte lost.");

  a_p0_lo_byte: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE8
    (wr_i && addr_i == OFS_P0_LO_LO)
    |=> st.path[0].lower[7:0] == $past(wdata_i))
    else $error("Lower limit low byte lost.");

  a_p1_hi_byte: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE8
    (wr_i && addr_i == OFS_P1_UP_HI)
    |=> st.path[1].upper[15:8] == $past(wdata_i))
    else $error("Upper limit high byte lost.");

  a_rms_lo_byte: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE8
    (wr_i && addr_i == OFS_RMS_LO_LO)
    |=> st.rms_lower[7:0] == $past(wdata_i))
    else $error("Power low limit byte lost.");

  a_fmt_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE2
    (wr_i && addr_i == OFS_P1_FMT)
    |=> st.path[1].wide == $past(wdata_i[0]))
    else $error("Format bit not written.");

  a_en_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE5
    (wr_i && addr_i == OFS_RMS_EN)
    |=> st.rms_on == $past(wdata_i[0]))
    else $error("Enable bit not written.");

  a_exp_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RULE6
    (wr_i && addr_i == OFS_RMS_EXP)
    |=> st.rms_exp == $past(wdata_i[4:0]))
    else $error("Block exponent not written.");
endmodule
`default_nettype wire

// *** hw/ipd_pkg.sv ***
// Overview of operation
// RULE1 - Crossing thresholds are signed 2.14 values
// RULE2 - Per path bit selects one or two-bit flag
// RULE3 - Peak flag sets when filter exceeds upper
// RULE4 - Flag clears after dwell below lower limit
// RULE5 - RMS detector runs only when enabled
// RULE6 - RMS block length is two to M
// RULE7 - Average power compared to high, low limits
// RULE8 - Settings built from low and high bytes
package ipd_pkg;
  localparam logic [7:0] OFS_P0_UP_LO   = 8'h0F;
  localparam logic [7:0] OFS_P0_UP_HI   = 8'h10;
  localparam logic [7:0] OFS_P0_LO_LO   = 8'h11;
  localparam logic [7:0] OFS_P0_LO_HI   = 8'h12;
  localparam logic [7:0] OFS_P0_FMT     = 8'h13;
  localparam logic [7:0] OFS_P1_UP_LO   = 8'h16;
  localparam logic [7:0] OFS_P1_UP_HI   = 8'h17;
  localparam logic [7:0] OFS_P1_LO_LO   = 8'h18;
  localparam logic [7:0] OFS_P1_LO_HI   = 8'h19;
  localparam logic [7:0] OFS_P1_FMT     = 8'h1A;
  localparam logic [7:0] OFS_HOLD_LO    = 8'h1D;
  localparam logic [7:0] OFS_HOLD_HI    = 8'h1E;
  localparam logic [7:0] OFS_RMS_EN     = 8'h20;
  localparam logic [7:0] OFS_RMS_EXP    = 8'h21;
  localparam logic [7:0] OFS_RMS_UP_LO  = 8'h22;
  localparam logic [7:0] OFS_RMS_UP_HI  = 8'h23;
  localparam logic [7:0] OFS_RMS_LO_LO  = 8'h24;
  localparam logic [7:0] OFS_RMS_LO_HI  = 8'h25;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h41;
  localparam logic [7:0] OFS_FLAGS      = 8'h42;
  localparam logic [4:0] RMS_EXP_MAX    = 5'h10;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  // Status bit positions: path0 set, path0 clear, path1 set, path1 clear, rms high, rms low.
  localparam int IRQ_W = 6;

  typedef struct packed {
    logic signed [15:0] upper;
    logic signed [15:0] lower;
    logic               wide;
  } ipd_path_cfg_s;

  typedef struct packed {
    ipd_path_cfg_s [1:0] path;
    logic [15:0]         hold;
    logic                rms_on;
    logic [4:0]          rms_exp;
    logic [15:0]         rms_upper;
    logic [15:0]         rms_lower;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic [1:0]          peak;
    logic [1:0][15:0]    dwell;
    logic [16:0]         blk_cnt;
    logic [47:0]         acc;
    logic [15:0]         avg;
    logic                avg_valid;
    logic [1:0]          rms_flag;
    logic [7:0]          rdata;
  } ipd_state_s;
endpackage

// *** verification/ipd_agc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the gain loop: it only reads the alarm flags and counts every new path or RMS high alarm.
module ipd_agc_model
  import ipd_pkg::*;
(
  input  wire logic            sys_clk_i,
  input  wire logic            nrst_i,
  input  wire logic [1:0][1:0] path_flag_i,
  input  wire logic [1:0]      rms_flag_i,
  output logic      [7:0]      backoff_cnt_o
);
  logic [2:0] last_al;
  logic [2:0] now_al;
  logic [2:0] rise;
  assign now_al = {rms_flag_i[0], path_flag_i[1][0], path_flag_i[0][0]};
  assign rise   = now_al & ~last_al;
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      last_al       <= 3'h0;
      backoff_cnt_o <= 8'h00;
    end else begin
      last_al       <= now_al;
      backoff_cnt_o <= backoff_cnt_o + 8'(rise[0]) + 8'(rise[1]) + 8'(rise[2]);
    end
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ipd_pkg::*;
  logic            sys_clk, nrst_n, wr, rd, avg_valid, irq;
  logic [7:0]      addr, wdata, rdata, agc_cnt, rb;
  logic [1:0][15:0] iir;
  logic [15:0]     power, avg;
  logic [1:0][1:0] pflag;
  logic [1:0]      rflag;
  int              err_count, checks_done, cyc;
  initial begin
    sys_clk = 1'b0; nrst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    iir = '0; power = 16'h0000; err_count = 0; checks_done = 0; cyc = 0;
  end
  always #10 sys_clk = ~sys_clk;
  ipd_detector dut_u (.sys_clk_i(sys_clk), .nrst_i(nrst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .iir_out_i(iir), .power_i(power), .path_flag_o(pflag), .rms_flag_o(rflag),
    .rms_avg_valid_o(avg_valid), .rms_avg_o(avg), .irq_o(irq));
  ipd_agc_model agc_u (.sys_clk_i(sys_clk), .nrst_i(nrst_n), .path_flag_i(pflag), .rms_flag_i(rflag),
    .backoff_cnt_o(agc_cnt));
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // The budget covers all scenarios with a wide margin; hitting it means a hang.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge sys_clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk) begin rd <= 1'b1; addr <= a; end
    @(posedge sys_clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst_n <= 1'b1;
    rd_reg(OFS_RMS_EN, rb); chk_reg(rb, 8'h00, "rms enable reset");
    rd_reg(8'h30, rb); chk_reg(rb, 8'h00, "unmapped read");
    wr_reg(OFS_RMS_EXP, 8'hFF); rd_reg(OFS_RMS_EXP, rb); chk_reg(rb, 8'h1F, "exponent field");
    wr_reg(OFS_P0_FMT, 8'hFF); rd_reg(OFS_P0_FMT, rb); chk_reg(rb, 8'h01, "format bit");
    wr_reg(OFS_P0_UP_LO, 8'h00); wr_reg(OFS_P0_UP_HI, 8'h08);
    wr_reg(OFS_P0_LO_LO, 8'h00); wr_reg(OFS_P0_LO_HI, 8'h04);
    wr_reg(OFS_HOLD_LO, 8'h02); wr_reg(OFS_HOLD_HI, 8'h00);
    rd_reg(OFS_P0_UP_HI, rb); chk_reg(rb, 8'h08, "upper high byte");
    // A negative sample must count as below the lower limit, which tests signed comparison.
    @(posedge sys_clk) iir[0] <= 16'h0C00;
    @(posedge sys_clk) iir[0] <= 16'hC000;
    #1 chk_sig({14'h0, pflag[0]}, 16'h0003, "peak set wide");
    chk_sig({14'h0, pflag[1]}, 16'h0000, "other path idle");
    tick(2); chk_sig({14'h0, pflag[0]}, 16'h0003, "peak before dwell");
    tick(1); chk_sig({14'h0, pflag[0]}, 16'h0000, "peak after dwell");
    chk_reg(agc_cnt, 8'h01, "gain loop saw alarm");
    rd_reg(OFS_IRQ_STAT, rb); chk_reg(rb, 8'h03, "set and clear events");
    chk_sig({15'h0, irq}, 16'h0000, "irq masked");
    wr_reg(OFS_IRQ_MASK, 8'h01); tick(1); chk_sig({15'h0, irq}, 16'h0001, "irq unmasked");
    wr_reg(OFS_IRQ_STAT, 8'h01); tick(1); chk_sig({15'h0, irq}, 16'h0000, "irq cleared");
    wr_reg(OFS_RMS_UP_LO, 8'h10); wr_reg(OFS_RMS_UP_HI, 8'h00);
    wr_reg(OFS_RMS_EXP, 8'h01); power <= 16'h0020;
    tick(4); chk_sig({15'h0, avg_valid}, 16'h0000, "detector off");
    wr_reg(OFS_RMS_EN, 8'h01);
    for (int i = 0; i < 20 && avg_valid !== 1'b1; i++) tick(1);
    chk_sig(avg, 16'h0020, "block average");
    tick(1); chk_sig({14'h0, rflag}, 16'h0001, "above high limit");
    wr_reg(OFS_RMS_EN, 8'h00); tick(2); chk_sig({14'h0, rflag}, 16'h0000, "flags off");
    // A block of one sample hands each power sample straight through.
    wr_reg(OFS_RMS_EXP, 8'h00); wr_reg(OFS_RMS_EN, 8'h01); power <= 16'h0055;
    tick(1); chk_sig(avg, 16'h0055, "unit block average");
    chk_sig({15'h0, avg_valid}, 16'h0001, "unit block valid");
    tick(1); chk_sig({14'h0, rflag}, 16'h0001, "unit block high");
    // A negative upper limit puts a zero sample above it, which only a signed compare sees.
    wr_reg(OFS_P1_UP_HI, 8'hC0); tick(1); chk_sig({14'h0, pflag[1]}, 16'h0001, "narrow path1 flag");
    rd_reg(OFS_FLAGS, rb); chk_reg(rb, 8'h06, "flag register");
    rd_reg(OFS_IRQ_STAT, rb); chk_reg(rb, 8'h16, "all events");
    chk_reg(agc_cnt, 8'h04, "gain loop alarms");
    conclude();
  end
endmodule
`default_nettype wire
